// ---- include/rx_mcast_map.vh ----
// register map, field layout and reset values of the rx filter block
`ifndef RX_MCAST_MAP_VH
`define RX_MCAST_MAP_VH

// byte offsets of the 16-bit registers on the host bus
`define HASH_WORD0_OFS 11'h1a0
`define HASH_WORD1_OFS 11'h1a2
`define HASH_WORD2_OFS 11'h1a4
`define HASH_WORD3_OFS 11'h1a6
`define LOW_MARK_OFS 11'h1b0
`define HIGH_MARK_OFS 11'h1b2
`define OVERRUN_MARK_OFS 11'h1b4
`define FRAME_COUNT_OFS 11'h1b8

// reset values
`define HASH_WORD_RST 16'h0000
`define LOW_MARK_RST 12'h600
`define HIGH_MARK_RST 12'h400
`define OVERRUN_MARK_RST 12'h040
`define FRAME_COUNT_RST 8'h00

// field positions
`define MARK_FIELD_MSB 11
`define FRAME_COUNT_LSB 8
`define HASH_INDEX_MSB 31
`define HASH_INDEX_LSB 26

// crc seed and generator
`define CRC_SEED 32'hffffffff
`define CRC_POLY 32'h04c11db7

`endif

// ---- verilog/mcast_hash_index.v ----
// crc over a 48-bit destination address, giving the 6-bit hash bin
`timescale 1ns/10ps
`include "rx_mcast_map.vh"

module mcast_hash_index (
  input wire [47:0] i_dest_addr,
  output reg [5:0] o_bin
);

  reg [31:0] crc;
  reg fb;
  integer k;

  // octets go first to last, each octet least significant bit first,
  // the order in which they cross the wire
  always @* begin
    crc = `CRC_SEED;
    fb = 1'b0;
    for (k = 0; k < 48; k = k + 1) begin
      fb = crc[31] ^ i_dest_addr[47 - 8 * (k / 8) - 7 + (k % 8)];
      crc = {crc[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
    end
    o_bin = crc[`HASH_INDEX_MSB:`HASH_INDEX_LSB];
  end

endmodule // mcast_hash_index

// ---- verilog/rx_multicast_hash_flow_ctrl.v ----
// multicast hash filter, rx queue watermarks and queued frame count
`timescale 1ns/10ps
`include "rx_mcast_map.vh"

// Behaviour
// - multicast frame accepted if its hash bin bit is one, else dropped.
// - receive-all plus address-filter bits accept every multicast frame.
// - 12-bit low watermark in dwords, reset 0x600 (6KB of 12KB).
// - 12-bit high watermark in dwords, reset 0x400 (4KB free).
// - 12-bit overrun watermark in dwords, reset 0x040 (256 bytes free).
// - upper byte reports frames queued, caught when rx interrupt is cleared.
// - reserved count low byte and watermark bits 15-12 read zero.
// - hash bin is crc top six bits; two pick word, four pick bit.
module rx_multicast_hash_flow_ctrl #(
  parameter MARK_W = 12,
  parameter COUNT_W = 8
) (
  input wire i_clk,
  input wire i_reset_n,
  // host parallel bus, 16-bit registers at byte addresses
  input wire i_bus_cs,
  input wire i_bus_wr,
  input wire i_bus_rd,
  input wire [10:0] i_bus_addr,
  input wire [1:0] i_bus_be,
  input wire [15:0] i_bus_wdata,
  output reg [15:0] o_bus_rdata,
  // receive control bits held elsewhere
  input wire i_receive_all,
  input wire i_mcast_addr_filter,
  // destination address of a frame under decision
  input wire i_da_valid,
  input wire [47:0] i_da,
  output reg o_frame_accept,
  output reg o_frame_drop,
  // receive queue state
  input wire [MARK_W-1:0] i_free_words,
  input wire [COUNT_W-1:0] i_frames_in_buffer,
  input wire i_rx_int_clear,
  output reg o_flow_ctrl,
  output reg o_overrun_discard
);

  reg [15:0] hash_word_r [0:3];
  reg [MARK_W-1:0] low_mark_r;
  reg [MARK_W-1:0] high_mark_r;
  reg [MARK_W-1:0] overrun_mark_r;
  reg [COUNT_W-1:0] frame_count_r;
  reg [15:0] rdata_nxt;
  reg flow_nxt;
  reg accept_nxt;
  wire wr_en;
  wire [5:0] hash_bin;
  wire da_multicast;
  wire bin_bit;
  wire pass_all;

  assign wr_en = i_bus_cs & i_bus_wr;

  // hash table words
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_hash
      // word address worked out wide, then trimmed to the bus width
      localparam [31:0] WORD_OFS_FULL = `HASH_WORD0_OFS + 2 * g;
      localparam [10:0] WORD_OFS = WORD_OFS_FULL[10:0];
      always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          hash_word_r[g] <= `HASH_WORD_RST;
        end else if (wr_en && i_bus_addr == WORD_OFS) begin
          if (i_bus_be[0]) begin
            hash_word_r[g][7:0] <= i_bus_wdata[7:0];
          end
          if (i_bus_be[1]) begin
            hash_word_r[g][15:8] <= i_bus_wdata[15:8];
          end
        end
      end
    end
  endgenerate

  // watermarks
  // bits 15-12 are not stored, so a write there has no effect
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_mark_r <= `LOW_MARK_RST;
      high_mark_r <= `HIGH_MARK_RST;
      overrun_mark_r <= `OVERRUN_MARK_RST;
    end else if (wr_en) begin
      case (i_bus_addr)
        `LOW_MARK_OFS: begin
          if (i_bus_be[0]) begin
            low_mark_r[7:0] <= i_bus_wdata[7:0];
          end
          if (i_bus_be[1]) begin
            low_mark_r[MARK_W-1:8] <= i_bus_wdata[MARK_W-1:8];
          end
        end
        `HIGH_MARK_OFS: begin
          if (i_bus_be[0]) begin
            high_mark_r[7:0] <= i_bus_wdata[7:0];
          end
          if (i_bus_be[1]) begin
            high_mark_r[MARK_W-1:8] <= i_bus_wdata[MARK_W-1:8];
          end
        end
        `OVERRUN_MARK_OFS: begin
          if (i_bus_be[0]) begin
            overrun_mark_r[7:0] <= i_bus_wdata[7:0];
          end
          if (i_bus_be[1]) begin
            overrun_mark_r[MARK_W-1:8] <= i_bus_wdata[MARK_W-1:8];
          end
        end
        default: begin
          low_mark_r <= low_mark_r;
        end
      endcase
    end
  end

  // queued frame count
  // snapshot only at the interrupt clear, so the host sees a stable
  // figure while it walks the frame headers
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frame_count_r <= `FRAME_COUNT_RST;
    end else if (i_rx_int_clear) begin
      frame_count_r <= i_frames_in_buffer;
    end
  end

  // register read
  always @* begin
    rdata_nxt = 16'h0000;
    case (i_bus_addr)
      `HASH_WORD0_OFS: rdata_nxt = hash_word_r[0];
      `HASH_WORD1_OFS: rdata_nxt = hash_word_r[1];
      `HASH_WORD2_OFS: rdata_nxt = hash_word_r[2];
      `HASH_WORD3_OFS: rdata_nxt = hash_word_r[3];
      `LOW_MARK_OFS: rdata_nxt = {4'h0, low_mark_r};
      `HIGH_MARK_OFS: rdata_nxt = {4'h0, high_mark_r};
      `OVERRUN_MARK_OFS: rdata_nxt = {4'h0, overrun_mark_r};
      `FRAME_COUNT_OFS: rdata_nxt = {frame_count_r, 8'h00};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // read data is held until the next read strobe
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bus_rdata <= 16'h0000;
    end else if (i_bus_cs && i_bus_rd) begin
      o_bus_rdata <= rdata_nxt;
    end
  end

  // multicast hash filter
  mcast_hash_index u_mcast_hash_index (
    .i_dest_addr(i_da),
    .o_bin(hash_bin)
  );

  // group bit is the low bit of the first octet on the wire
  assign da_multicast = i_da[40];
  assign bin_bit = hash_word_r[hash_bin[5:4]][hash_bin[3:0]];
  assign pass_all = i_receive_all & i_mcast_addr_filter;

  // frames that are not multicast are left to other filters: accepted here
  always @* begin
    accept_nxt = 1'b1;
    if (da_multicast) begin
      accept_nxt = pass_all | bin_bit;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_frame_accept <= 1'b0;
      o_frame_drop <= 1'b0;
    end else begin
      o_frame_accept <= i_da_valid & accept_nxt;
      o_frame_drop <= i_da_valid & ~accept_nxt;
    end
  end

  // flow control
  // hysteresis between the two marks keeps pause from chattering;
  // free space equal to a mark changes nothing
  always @* begin
    flow_nxt = o_flow_ctrl;
    if (i_free_words < high_mark_r) begin
      flow_nxt = 1'b1;
    end else if (i_free_words > low_mark_r) begin
      flow_nxt = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flow_ctrl <= 1'b0;
      o_overrun_discard <= 1'b0;
    end else begin
      o_flow_ctrl <= flow_nxt;
      o_overrun_discard <= (i_free_words < overrun_mark_r);
    end
  end

endmodule // rx_multicast_hash_flow_ctrl

// ---- dv/rx_mcast_monitor.sv ----
// concurrent checks on the rx filter block ports
`timescale 1ns/10ps
module rx_mcast_monitor #(parameter MARK_W = 12, parameter COUNT_W = 8) (
  input wire i_clk, input wire i_reset_n, input wire i_bus_cs,
  input wire i_bus_rd, input wire [10:0] i_bus_addr,
  input wire [15:0] o_bus_rdata, input wire i_receive_all,
  input wire i_mcast_addr_filter, input wire i_da_valid,
  input wire [47:0] i_da, input wire o_frame_accept,
  input wire o_frame_drop, input wire [MARK_W-1:0] i_free_words,
  input wire [COUNT_W-1:0] i_frames_in_buffer,
  input wire i_rx_int_clear, input wire o_flow_ctrl,
  input wire o_overrun_discard
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire rd = i_bus_cs && i_bus_rd;
  sequence s_clr; i_rx_int_clear; endsequence
  sequence s_rdcnt; rd && i_bus_addr == 11'h1b8; endsequence
  property p_resp; i_da_valid |=> o_frame_accept ^ o_frame_drop; endproperty
  a_resp: assert property (p_resp) else $error("no single verdict");
  property p_idle; !i_da_valid |=> !o_frame_accept && !o_frame_drop;
  endproperty
  a_idle: assert property (p_idle) else $error("stray verdict");
  property p_ucast; i_da_valid && !i_da[40] |=> o_frame_accept; endproperty
  a_ucast: assert property (p_ucast) else $error("unicast lost");
  property p_all; i_da_valid && i_da[40] && i_receive_all &&
    i_mcast_addr_filter |=> o_frame_accept; endproperty
  a_all: assert property (p_all) else $error("multicast lost");
  property p_mark; rd && i_bus_addr inside {11'h1b0, 11'h1b2, 11'h1b4}
    |=> o_bus_rdata[15:12] == 4'h0; endproperty
  a_mark: assert property (p_mark) else $error("mark top bits");
  property p_odd; rd && i_bus_addr[0] |=> o_bus_rdata == 16'h0000;
  endproperty
  a_odd: assert property (p_odd) else $error("odd read not 0");
  property p_cntlo; s_rdcnt |=> o_bus_rdata[7:0] == 8'h00; endproperty
  a_cntlo: assert property (p_cntlo) else $error("count low byte");
  property p_cnt; s_clr ##1 s_rdcnt
    |=> o_bus_rdata[15:8] == $past(i_frames_in_buffer, 2); endproperty
  a_cnt: assert property (p_cnt) else $error("frame count");
  property p_full; i_free_words == 12'hfff
    |=> !o_flow_ctrl && !o_overrun_discard; endproperty
  a_full: assert property (p_full) else $error("flow on when free");
  property p_empty; i_free_words == 12'h000
    |=> o_flow_ctrl && o_overrun_discard; endproperty
  a_empty: assert property (p_empty) else $error("flow off at 0");
endmodule // rx_mcast_monitor

// ---- dv/host_bus_model.sv ----
// host processor model on the parallel register bus
`timescale 1ns/10ps
module host_bus_model (
  input wire i_clk, input wire [15:0] i_rdata,
  output reg o_cs, output reg o_wr, output reg o_rd, output reg o_int_clear,
  output reg [10:0] o_addr, output reg [1:0] o_be, output reg [15:0] o_wdata
);
  initial {o_cs, o_wr, o_rd, o_int_clear, o_addr, o_be, o_wdata} = 0;
  task acc(input bit w, input [10:0] a, input [1:0] b, input [15:0] d);
    @(negedge i_clk);
    {o_cs, o_wr, o_rd, o_int_clear} = {1'b1, w, !w, 1'b0};
    {o_addr, o_be, o_wdata} = {a, b, d};
    @(negedge i_clk);
    // released strobes drop and address and data flip so a stale value never looks live
    {o_cs, o_wr, o_rd, o_addr, o_wdata} = {3'b000, ~a, ~d};
  endtask
  task rd(input [10:0] a, output [15:0] d);
    acc(0, a, 2'b11, 16'h0000);
    @(negedge i_clk);
    d = i_rdata;
  endtask
  // clear the rx flag, then the count read comes before any header
  task service(output [15:0] d);
    @(negedge i_clk);
    o_int_clear = 1;
    rd(11'h1b8, d);
  endtask
endmodule // host_bus_model

// ---- dv/test_rx_multicast_hash_flow_ctrl.sv ----
// self-checking bench for the rx multicast filter and flow control
`timescale 1ns/10ps
module test_rx_multicast_hash_flow_ctrl;
  reg i_clk = 0, i_reset_n = 0, i_receive_all = 0, i_mcast_addr_filter = 0;
  reg i_da_valid = 0, e;
  reg [47:0] i_da = 0;
  reg [11:0] i_free_words = 12'h800;
  reg [7:0] i_frames_in_buffer = 0, n;
  wire i_bus_cs, i_bus_wr, i_bus_rd, i_rx_int_clear, o_frame_accept;
  wire o_frame_drop, o_flow_ctrl, o_overrun_discard;
  wire [10:0] i_bus_addr;
  wire [1:0] i_bus_be;
  wire [15:0] i_bus_wdata, o_bus_rdata;
  int bad_count = 0, tests_run = 0;
  reg [15:0] ht [4], v;
  reg [5:0] b;
  reg fc_m = 0;
  reg [10:0] ra [10] = '{11'h1a0, 11'h1a2, 11'h1a4, 11'h1a6, 11'h1b0,
    11'h1b2, 11'h1b4, 11'h1b8, 11'h1a8, 11'h1b1};
  reg [15:0] re [10] = '{0, 0, 0, 0, 16'h0600, 16'h0400, 16'h0040, 0, 0, 0};
  reg [11:0] fw [10] = '{12'h000, 12'h01f, 12'h020, 12'h0a0, 12'h100,
    12'h101, 12'h0a0, 12'h080, 12'h07f, 12'hfff};
  always #2.5 i_clk = ~i_clk;
  rx_multicast_hash_flow_ctrl u_rx_multicast_hash_flow_ctrl (.*);
  host_bus_model u_host_bus_model (.i_clk(i_clk), .i_rdata(o_bus_rdata),
    .o_cs(i_bus_cs), .o_wr(i_bus_wr), .o_rd(i_bus_rd), .o_be(i_bus_be),
    .o_int_clear(i_rx_int_clear), .o_addr(i_bus_addr), .o_wdata(i_bus_wdata));
  task chk(input string s, input [15:0] x, input [15:0] g);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function [5:0] bin(input [47:0] a);
    reg [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 48; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ a[40-8*(i/8)+i%8]) ? 32'h04c11db7 : 0);
    bin = c[31:26];
  endfunction
  initial begin
    #50000;
    bad_count++;
    $display("[FAIL] watchdog exp done got hang");
    end_sim;
  end
  initial begin
    v = $urandom(32'h8ac0);
    repeat (20) @(negedge i_clk);
    i_reset_n = 1;
    foreach (ra[i]) begin
      u_host_bus_model.rd(ra[i], v);
      chk("reset", re[i], v);
    end
    $display("done reset");
    for (int i = 0; i < 3; i++) begin
      u_host_bus_model.acc(1, 11'h1b0 + 2 * i, 2'b11, 16'hffff);
      u_host_bus_model.rd(11'h1b0 + 2 * i, v);
      chk("mark", 16'h0fff, v);
    end
    u_host_bus_model.acc(1, 11'h1b2, 2'b01, 16'h1234);
    u_host_bus_model.rd(11'h1b2, v);
    chk("byte lane", 16'h0f34, v);
    u_host_bus_model.acc(1, 11'h1b0, 2'b11, 16'h0100);
    u_host_bus_model.acc(1, 11'h1b2, 2'b11, 16'h0080);
    u_host_bus_model.acc(1, 11'h1b4, 2'b11, 16'h0020);
    $display("done marks");
    for (int i = 0; i < 4; i++) begin
      ht[i] = $urandom;
      u_host_bus_model.acc(1, 11'h1a0 + 2 * i, 2'b11, ht[i]);
      u_host_bus_model.rd(11'h1a0 + 2 * i, v);
      chk("hash word", ht[i], v);
    end
    repeat (60) begin
      @(negedge i_clk);
      i_da = {$urandom, $urandom};
      {i_receive_all, i_mcast_addr_filter} = $urandom;
      i_da_valid = 1;
      b = bin(i_da);
      e = !i_da[40] || (i_receive_all && i_mcast_addr_filter) ||
        ht[b[5:4]][b[3:0]];
      @(negedge i_clk);
      i_da_valid = 0;
      v = {o_frame_accept, o_frame_drop};
      chk("filter", {e, !e}, v);
    end
    $display("done filter");
    foreach (fw[i]) begin
      @(negedge i_clk);
      i_free_words = fw[i];
      @(negedge i_clk);
      if (fw[i] < 12'h080) fc_m = 1;
      else if (fw[i] > 12'h100) fc_m = 0;
      v = {o_flow_ctrl, o_overrun_discard};
      chk("flow", {fc_m, fw[i] < 12'h020}, v);
    end
    $display("done flow");
    n = $urandom;
    i_frames_in_buffer = n;
    u_host_bus_model.service(v);
    chk("count", {n, 8'h00}, v);
    i_frames_in_buffer = ~n;
    u_host_bus_model.acc(1, 11'h1b8, 2'b11, 16'hffff);
    u_host_bus_model.rd(11'h1b8, v);
    chk("count held", {n, 8'h00}, v);
    $display("done count");
    end_sim;
  end
endmodule // test_rx_multicast_hash_flow_ctrl
bind rx_multicast_hash_flow_ctrl rx_mcast_monitor #(.MARK_W(MARK_W),
  .COUNT_W(COUNT_W)) u_rx_mcast_monitor (.*);
